// ### pkg/cwt_pkg.sv
// Constants, register map and command codes of the carrier wave timer
package cwt_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CNT_W = 8;
  localparam int NIB_W = 4;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_SRC_BIT = 1;
  localparam int CTL_CARR_BIT = 2;
  localparam int CTL_EXP_BIT = 3;
  localparam logic [3:0] CTL_RST = 4'h0;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_CTL = 4'h4;
  localparam logic [3:0] OFS_CNT = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  localparam logic [3:0] OFS_MASK = 4'h2;

  // ****************************************************************
  // Command register layout: data in [7:0], code in [10:8]
  // ****************************************************************
  localparam int CMD_DAT_LSB = 0;
  localparam int CMD_CODE_LSB = 8;
  localparam logic [2:0] CMD_LOAD_CNT_LOW = 3'h1;
  localparam logic [2:0] CMD_RELOAD_FROM_LOW = 3'h2;
  localparam logic [2:0] CMD_LOAD_HIGH = 3'h3;
  localparam logic [2:0] CMD_SKIP_DIV = 3'h4;
  localparam logic [2:0] CMD_SKIP_CARR = 3'h5;

  // ****************************************************************
  // Status bits
  // ****************************************************************
  localparam int ST_DIV_BIT = 0;
  localparam int ST_CARR_BIT = 1;
  localparam logic [7:0] CNT_RST = 8'h00;

endpackage

// ### pkg/flag_if.sv
// Underflow flag pair carried between timer core and flag unit
`timescale 1ns/100ps
interface flag_if;
  logic div_uf;
  logic carr_uf;
  logic skip_div;
  logic skip_carr;
  logic div_flag;
  logic carr_flag;
  logic skip_taken;

  modport timer
  (
    output div_uf,
    output carr_uf,
    output skip_div,
    output skip_carr,
    input div_flag,
    input carr_flag,
    input skip_taken
  );

  modport flags
  (
    input div_uf,
    input carr_uf,
    input skip_div,
    input skip_carr,
    output div_flag,
    output carr_flag,
    output skip_taken
  );
endinterface

// ### rtl/uf_flags.sv
// Underflow flags of both timers with skip test and clear
`timescale 1ns/100ps
module uf_flags
  import cwt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  flag_if.flags fi
);
  typedef struct packed
  {
    logic div_f;
    logic carr_f;
    logic taken;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  // ****************************************************************
  // Flags: set wins over skip clear
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    if (fi.skip_div || fi.skip_carr)
    begin
      s_nxt.taken = (fi.skip_div && s_r.div_f) || (fi.skip_carr && s_r.carr_f);
    end
    if (fi.skip_div && s_r.div_f)
    begin
      s_nxt.div_f = 1'b0;
      s_nxt.taken = 1'b1;
    end
    if (fi.skip_carr && s_r.carr_f)
    begin
      s_nxt.carr_f = 1'b0;
      s_nxt.taken = 1'b1;
    end
    if (fi.div_uf)
    begin
      s_nxt.div_f = 1'b1;
    end
    if (fi.carr_uf)
    begin
      s_nxt.carr_f = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign fi.div_flag = s_r.div_f;
  assign fi.carr_flag = s_r.carr_f;
  assign fi.skip_taken = s_r.taken;

  property p_flag_set;
    @(posedge clk) disable iff (!rst_n) fi.carr_uf |=> fi.carr_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_clr;
    @(posedge clk) disable iff (!rst_n)
      fi.skip_carr && fi.carr_flag && !fi.carr_uf |=> !fi.carr_flag && fi.skip_taken;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_skip_none;
    @(posedge clk) disable iff (!rst_n)
      fi.skip_div && !fi.div_flag && !fi.skip_carr |=> !fi.skip_taken;
  endproperty
  a_skip_none: assert property (p_skip_none) else $error("false skip");
endmodule

// ### rtl/carrier_wave_timer.sv
// Carrier wave timer: down counter, reload registers, carrier output, bus slave
`timescale 1ns/100ps
module carrier_wave_timer
  import cwt_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic div_uf_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic carrier_out,
  output logic carrier_uf,
  output logic irq
);
  typedef struct packed
  {
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] low_interval_reload;
    logic [WIDTH-1:0] high_interval_reload;
    logic [3:0] carrier_timer_control;
    logic half_ph;
    logic high_ph;
    logic ext_half;
    logic carr;
    logic uf;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic ack;
    logic tick_s1;
    logic tick_s2;
    logic dv_s1;
    logic dv_s2;
    logic dv_d;
  } st_t;

  st_t s_r;
  st_t s_nxt;
  flag_if fi ();

  logic run;
  logic src_half;
  logic carr_en;
  logic exp_en;
  logic pulse;
  logic [2:0] code;
  logic wr;
  logic rd;
  logic [WIDTH-1:0] wdat;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] zext(input logic [WIDTH-1:0] v);
    zext = 32'(v);
  endfunction

  assign run = s_r.carrier_timer_control[CTL_RUN_BIT];
  assign src_half = s_r.carrier_timer_control[CTL_SRC_BIT];
  assign carr_en = s_r.carrier_timer_control[CTL_CARR_BIT];
  assign exp_en = s_r.carrier_timer_control[CTL_EXP_BIT];
  assign wr = avs_write && !s_r.ack;
  assign rd = avs_read && !s_r.ack;
  assign code = avs_writedata[CMD_CODE_LSB +: 3];
  assign wdat = avs_writedata[CMD_DAT_LSB +: WIDTH];
  // Count pulse: synchronized oscillator tick, optionally halved
  assign pulse = s_r.tick_s2 && (!src_half || s_r.half_ph);

  assign fi.div_uf = s_r.dv_s2 && !s_r.dv_d;
  assign fi.carr_uf = s_r.uf;
  assign fi.skip_div = wr && avs_address == OFS_CMD && code == CMD_SKIP_DIV;
  assign fi.skip_carr = wr && avs_address == OFS_CMD && code == CMD_SKIP_CARR;

  uf_flags u_flags
  (
    .clk(clk),
    .rst_n(rst_n),
    .fi(fi)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.uf = 1'b0;
    s_nxt.ack = avs_read || avs_write ? !s_r.ack : 1'b0;
    s_nxt.tick_s1 = osc_tick;
    s_nxt.tick_s2 = s_r.tick_s1;
    s_nxt.dv_s1 = div_uf_in;
    s_nxt.dv_s2 = s_r.dv_s1;
    s_nxt.dv_d = s_r.dv_s2;
    if (s_r.tick_s2)
    begin
      s_nxt.half_ph = !s_r.half_ph;
    end
    if (!run)
    begin
      s_nxt.half_ph = 1'b0;
    end
    if (run && s_r.ext_half && s_r.tick_s2)
    begin
      // Extra part of the high interval ends on the next source tick
      // Half source: exactly half a count period; full source: one whole tick
      s_nxt.ext_half = 1'b0;
      s_nxt.uf = 1'b1;
      s_nxt.cnt = s_r.low_interval_reload;
      s_nxt.high_ph = 1'b0;
      s_nxt.carr = 1'b0;
      s_nxt.half_ph = 1'b0;
    end
    else if (run && pulse)
    begin
      if (s_r.cnt == '0 && carr_en && exp_en && s_r.high_ph)
      begin
        s_nxt.ext_half = 1'b1;
      end
      else if (s_r.cnt == '0)
      begin
        s_nxt.uf = 1'b1;
        if (carr_en && !s_r.high_ph)
        begin
          s_nxt.cnt = s_r.high_interval_reload;
          s_nxt.high_ph = 1'b1;
          s_nxt.carr = 1'b1;
        end
        else
        begin
          s_nxt.cnt = s_r.low_interval_reload;
          s_nxt.high_ph = 1'b0;
          s_nxt.carr = 1'b0;
        end
      end
      else
      begin
        s_nxt.cnt = s_r.cnt - WIDTH'(1);
      end
    end
    if (!run || !carr_en)
    begin
      s_nxt.carr = 1'b0;
      s_nxt.high_ph = 1'b0;
      s_nxt.ext_half = 1'b0;
    end
    if (wr && avs_address == OFS_CMD)
    begin
      case (code)
        CMD_LOAD_CNT_LOW:
        begin
          s_nxt.cnt = wdat;
          s_nxt.low_interval_reload = wdat;
        end
        CMD_RELOAD_FROM_LOW: s_nxt.cnt = s_r.low_interval_reload;
        CMD_LOAD_HIGH: s_nxt.high_interval_reload = wdat;
        default: s_nxt.cnt = s_nxt.cnt;
      endcase
    end
    if (wr && avs_address == OFS_CTL)
    begin
      s_nxt.carrier_timer_control = avs_writedata[3:0];
    end
    if (wr && avs_address == OFS_MASK)
    begin
      s_nxt.mask = avs_writedata[1:0];
    end
    if (wr && avs_address == OFS_STAT)
    begin
      s_nxt.stat = s_r.stat & ~avs_writedata[1:0];
    end
    if (fi.div_uf)
    begin
      s_nxt.stat[ST_DIV_BIT] = 1'b1;
    end
    if (s_r.uf)
    begin
      s_nxt.stat[ST_CARR_BIT] = 1'b1;
    end
    s_nxt.rdata = '0;
    if (rd)
    begin
      case (avs_address)
        OFS_CMD: s_nxt.rdata = {29'h0, fi.skip_taken, fi.carr_flag, fi.div_flag};
        OFS_CTL: s_nxt.rdata = {28'h0, s_r.carrier_timer_control};
        OFS_CNT: s_nxt.rdata = zext(s_r.cnt);
        OFS_STAT: s_nxt.rdata = {30'h0, s_r.stat};
        OFS_MASK: s_nxt.rdata = {30'h0, s_r.mask};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.carrier_timer_control <= CTL_RST;
      s_r.cnt <= CNT_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
  assign avs_readdata = s_r.rdata;
  assign carrier_out = s_r.carr;
  assign carrier_uf = s_r.uf;
  assign irq = |(s_r.stat & s_r.mask);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_load;
    @(posedge clk) disable iff (!rst_n)
      wr && avs_address == OFS_CMD && code == CMD_LOAD_CNT_LOW
      |=> s_r.cnt == $past(wdat) && s_r.low_interval_reload == $past(wdat);
  endproperty
  a_load: assert property (p_load) else $error("load failed");

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
      wr && avs_address == OFS_CMD && code == CMD_RELOAD_FROM_LOW
      |=> s_r.cnt == $past(s_r.low_interval_reload);
  endproperty
  a_reload: assert property (p_reload) else $error("reload failed");

  property p_high;
    @(posedge clk) disable iff (!rst_n)
      wr && avs_address == OFS_CMD && code == CMD_LOAD_HIGH
      |=> s_r.high_interval_reload == $past(wdat) && $stable(s_r.low_interval_reload);
  endproperty
  a_high: assert property (p_high) else $error("high load failed");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !run && !wr |=> $stable(s_r.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved");

  property p_div_uf;
    @(posedge clk) disable iff (!rst_n)
      run && pulse && !carr_en && s_r.cnt == '0 && !wr
      |=> carrier_uf && s_r.cnt == $past(s_r.low_interval_reload);
  endproperty
  a_div_uf: assert property (p_div_uf) else $error("divider reload");

  property p_dec;
    @(posedge clk) disable iff (!rst_n)
      run && pulse && !carr_en && s_r.cnt != '0 && !wr |=> s_r.cnt == $past(s_r.cnt) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");

  property p_low;
    @(posedge clk) disable iff (!rst_n) !carr_en || !run |=> !carrier_out;
  endproperty
  a_low: assert property (p_low) else $error("carrier not low");

  property p_alt;
    @(posedge clk) disable iff (!rst_n)
      run && carr_en && pulse && !s_r.ext_half && s_r.cnt == '0 && !s_r.high_ph && !wr
      |=> carrier_out && s_r.cnt == $past(s_r.high_interval_reload);
  endproperty
  a_alt: assert property (p_alt) else $error("high not loaded");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      carrier_uf && s_r.mask[ST_CARR_BIT] && !(wr && avs_address == OFS_MASK) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  c_uf: cover property (@(posedge clk) disable iff (!rst_n) carrier_uf);
  c_carr: cover property (@(posedge clk) disable iff (!rst_n) $rose(carrier_out));
  c_ext: cover property (@(posedge clk) disable iff (!rst_n) s_r.ext_half);
endmodule

// ### sim/osc_src_model.sv
// Oscillator tick and divider underflow source facing the timer
`timescale 1ns/100ps
module osc_src_model
#(
  parameter int PER = 4
)
(
  input wire logic clk,
  input wire logic tick_en,
  input wire logic div_req,
  output logic osc_tick,
  output logic div_uf_in
);
  int ph_r = 0;

  initial
  begin
    osc_tick = 1'b0;
    div_uf_in = 1'b0;
  end

  // One-cycle tick every PER clocks while enabled
  always @(posedge clk)
  begin
    ph_r <= (ph_r == PER - 1) ? 0 : ph_r + 1;
    osc_tick <= tick_en && (ph_r == 0);
    div_uf_in <= div_req;
  end
endmodule

// ### sim/carrier_wave_timer_tb_top.sv
// Self-checking bench for the carrier wave timer
`timescale 1ns/100ps
module carrier_wave_timer_tb_top
  import cwt_pkg::*;
;
  localparam int P = 4;
  logic clk;
  logic rst_n;
  logic tick_en;
  logic div_req;
  logic osc_tick;
  logic div_uf_in;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic carrier_out;
  logic carrier_uf;
  logic irq;
  logic [31:0] rdat;
  int failures = 0;
  int checks_done = 0;
  int g;

  carrier_wave_timer #(.WIDTH(CNT_W)) DUT
  (
    .clk(clk), .rst_n(rst_n), .osc_tick(osc_tick), .div_uf_in(div_uf_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .carrier_out(carrier_out),
    .carrier_uf(carrier_uf), .irq(irq)
  );

  osc_src_model #(.PER(P)) src
  (
    .clk(clk), .tick_en(tick_en), .div_req(div_req),
    .osc_tick(osc_tick), .div_uf_in(div_uf_in)
  );

  // ********************
  // Bus and check tasks
  // ********************
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task bus(input logic is_rd, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= is_rd;
    avs_write <= !is_rd;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
      failures++;
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task rd(input logic [3:0] a);
    bus(1'b1, a, 32'h0);
  endtask

  task cmd(input logic [2:0] c, input logic [7:0] v);
    bus(1'b0, OFS_CMD, {21'h0, c, v});
  endtask

  task pins(input logic c, input logic i);
    @(negedge clk);
    chk("carrier_out", carrier_out, c);
    chk("irq", irq, i);
    @(posedge clk);
  endtask

  task run_ticks(input int k);
    int n;
    n = 0;
    tick_en <= 1'b1;
    while (n < k)
    begin
      @(negedge clk);
      if (osc_tick === 1'b1)
        n++;
    end
    @(posedge clk);
    tick_en <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task uf_gap(output int gp);
    int k;
    k = 0;
    while (carrier_uf !== 1'b1 && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    gp = 0;
    do
    begin
      @(negedge clk);
      gp++;
    end
    while (carrier_uf !== 1'b1 && gp < 4000);
    @(posedge clk);
  endtask

  task lvl_len(input logic v, output int gp);
    int k;
    k = 0;
    while (carrier_out === v && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    while (carrier_out !== v && k < 8000)
    begin
      @(negedge clk);
      k++;
    end
    gp = 0;
    while (carrier_out === v && gp < 4000)
    begin
      @(negedge clk);
      gp++;
    end
    @(posedge clk);
  endtask

  // ********************
  // Scenarios
  // ********************
  task t_reset;
    pins(1'b0, 1'b0);
    rd(OFS_CNT);
    chk("count", rdat, 32'h0);
    rd(4'h6);
    chk("unmapped", rdat, 32'h0);
    $display("test reset done");
  endtask

  task t_count;
    cmd(CMD_LOAD_CNT_LOW, 8'h07);
    rd(OFS_CNT);
    chk("load", rdat, 32'h07);
    wr(OFS_CTL, 32'h1);
    run_ticks(3);
    wr(OFS_CTL, 32'h0);
    rd(OFS_CNT);
    chk("count down", rdat, 32'h04);
    run_ticks(2);
    cmd(CMD_LOAD_HIGH, 8'h33);
    rd(OFS_CNT);
    chk("held", rdat, 32'h04);
    cmd(CMD_RELOAD_FROM_LOW, 8'h00);
    rd(OFS_CNT);
    chk("reload", rdat, 32'h07);
    $display("test count done");
  endtask

  task t_div;
    logic [7:0] nv [3] = '{8'h00, 8'h05, 8'hff};
    for (int s = 0; s < 2; s++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cmd(CMD_LOAD_CNT_LOW, nv[i]);
        wr(OFS_CTL, 32'h1 | (s << 1));
        tick_en <= 1'b1;
        uf_gap(g);
        chk("divider gap", g, (nv[i] + 1) * P * (s + 1));
        pins(1'b0, 1'b0);
        tick_en <= 1'b0;
        wr(OFS_CTL, 32'h0);
      end
    end
    rd(OFS_STAT);
    chk("carrier status", rdat[1], 1'b1);
    $display("test divider done");
  endtask

  task t_carrier;
    logic [7:0] mv [4] = '{8'h02, 8'h00, 8'h02, 8'h02};
    logic [7:0] hv [4] = '{8'h01, 8'h00, 8'h01, 8'h01};
    logic [31:0] cv [4] = '{32'h5, 32'h5, 32'hd, 32'hf};
    int sc;
    for (int i = 0; i < 4; i++)
    begin
      sc = (i == 3) ? 2 : 1;
      cmd(CMD_LOAD_CNT_LOW, mv[i]);
      cmd(CMD_LOAD_HIGH, hv[i]);
      wr(OFS_CTL, cv[i]);
      tick_en <= 1'b1;
      lvl_len(1'b0, g);
      chk("low time", g, (mv[i] + 1) * P * sc);
      lvl_len(1'b1, g);
      if (i < 2)
        chk("high time", g, (hv[i] + 1) * P);
      else if (i == 2)
        chk("expanded", g > (hv[i] + 1) * P && g <= (hv[i] + 2) * P, 1'b1);
      else
        chk("expanded half", g, (2 * hv[i] + 3) * P);
      tick_en <= 1'b0;
      wr(OFS_CTL, 32'h0);
      pins(1'b0, 1'b0);
    end
    $display("test carrier done");
  endtask

  task t_flags;
    rd(OFS_CMD);
    chk("carrier flag", rdat[2:0], 3'b010);
    cmd(CMD_SKIP_CARR, 8'h00);
    rd(OFS_CMD);
    chk("skip taken", rdat[2:0], 3'b100);
    cmd(CMD_SKIP_CARR, 8'h00);
    rd(OFS_CMD);
    chk("flag stays clear", rdat[1], 1'b0);
    chk("no skip", rdat[2:0], 3'b000);
    wr(OFS_MASK, 32'h3);
    pins(1'b0, 1'b1);
    wr(OFS_STAT, 32'h2);
    pins(1'b0, 1'b0);
    div_req <= 1'b1;
    repeat (6) @(posedge clk);
    div_req <= 1'b0;
    repeat (4) @(posedge clk);
    pins(1'b0, 1'b1);
    rd(OFS_CMD);
    chk("divider flag", rdat[2:0], 3'b001);
    cmd(CMD_SKIP_DIV, 8'h00);
    rd(OFS_CMD);
    chk("divider skip", rdat[2:0], 3'b100);
    wr(OFS_STAT, 32'h1);
    pins(1'b0, 1'b0);
    rd(OFS_STAT);
    chk("status clear", rdat[1:0], 2'b00);
    $display("test flags done");
  endtask

  // ********************
  // Clock, reset and run
  // ********************
  task close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    close_out;
  end

  initial
  begin
    rst_n = 1'b0;
    tick_en = 1'b0;
    div_req = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_count;
    t_div;
    t_carrier;
    t_flags;
    close_out;
  end
endmodule
